// file: hdl/ctc_cycle_timing.sv
// Implementation choice: the APB register port.
`timescale 1ns/100ps
module ctc_cycle_timing #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rstn,
	// APB slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Ordinary port function of port 3 bit 4
	input  wire logic              gpioOut,
	input  wire logic              gpioOe,
	// Core timing
	output logic                   machineCycleStrobe,
	output logic [2:0]             instrTiming,
	// Port 3 bit 4 pad
	output logic                   port3Bit4Out,
	output logic                   port3Bit4Oe
);
	import ctc_pkg::*;

	// Register bus state.
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic        pready_ff;
	logic        nxt_pready;
	logic        pslverr_ff;
	logic        nxt_pslverr;

	// Configuration state.
	logic [2:0]  its_ff;
	logic [2:0]  nxt_its;
	ctc_sel_type outSel_ff;
	ctc_sel_type nxt_outSel;

	// Machine cycle state.
	logic        oscPhase_ff;
	logic        nxt_oscPhase;
	logic [2:0]  cycleCnt_ff;
	logic [2:0]  nxt_cycleCnt;
	logic        strobe_ff;
	logic        nxt_strobe;

	// Bus decode.
	logic        setupPhase;
	logic        accessDone;
	logic        hitCfg;
	logic        hitStat;
	logic        wrCfg;
	logic [7:0]  cfgView;
	logic [7:0]  statView;

	assign setupPhase = psel && !penable;
	assign accessDone = psel && penable && pready_ff;
	assign hitCfg     = (paddr == CTC_CFG_ADDR[ADDR_W-1:0]);
	assign hitStat    = (paddr == CTC_STAT_ADDR[ADDR_W-1:0]);
	assign wrCfg      = accessDone && pwrite && hitCfg && pstrb[0];

	always_comb begin
		cfgView = 8'h00;
		cfgView[CTC_ITS_MSB:CTC_ITS_LSB] = its_ff;
		cfgView[CTC_SEL_MSB:CTC_SEL_LSB] = outSel_ff;
		statView = 8'h00;
		statView[CTC_STAT_CNT_LSB +: 3] = cycleCnt_ff;
		statView[CTC_STAT_PHASE] = oscPhase_ff;
		statView[CTC_STAT_PIN] = port3Bit4Out;
	end

	// Read data is captured in the setup cycle so that every bus output comes from a flop.
	// The cost is a fixed single access cycle; no transfer ever waits longer.
	always_comb begin
		nxt_pready  = setupPhase;
		nxt_pslverr = setupPhase && !(hitCfg || hitStat);
		nxt_prdata  = prdata_ff;
		if (setupPhase) begin
			if (pwrite) begin
				nxt_prdata = 32'h0000_0000;
			end else if (hitCfg) begin
				nxt_prdata = {24'h00_0000, cfgView};
			end else if (hitStat) begin
				nxt_prdata = {24'h00_0000, statView};
			end else begin
				nxt_prdata = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// Both fields are live: a write lands on the access edge and the logic uses it from the next cycle.
	always_comb begin
		nxt_its    = its_ff;
		nxt_outSel = outSel_ff;
		if (wrCfg) begin
			nxt_its    = pwdata[CTC_ITS_MSB:CTC_ITS_LSB];
			nxt_outSel = ctc_sel_type'(pwdata[CTC_SEL_MSB:CTC_SEL_LSB]);
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			its_ff    <= CTC_ITS_RST;
			outSel_ff <= CTC_SEL_RST;
		end else begin
			its_ff    <= nxt_its;
			outSel_ff <= nxt_outSel;
		end
	end

	// The count wraps on reaching the field value or anything above it, so shrinking the
	// field mid-cycle ends the current machine cycle at the next oscillator clock.
	always_comb begin
		nxt_oscPhase = !oscPhase_ff;
		nxt_cycleCnt = cycleCnt_ff;
		nxt_strobe   = 1'b0;
		if (oscPhase_ff) begin
			if (cycleCnt_ff >= its_ff) begin
				nxt_cycleCnt = CTC_CNT_RST;
				nxt_strobe   = 1'b1;
			end else begin
				nxt_cycleCnt = cycleCnt_ff + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			oscPhase_ff <= 1'b0;
			cycleCnt_ff <= CTC_CNT_RST;
			strobe_ff   <= 1'b0;
		end else begin
			oscPhase_ff <= nxt_oscPhase;
			cycleCnt_ff <= nxt_cycleCnt;
			strobe_ff   <= nxt_strobe;
		end
	end

	ctc_clock_out u_clock_out (
		.mclk    (mclk),
		.rstn    (rstn),
		.outSel  (outSel_ff),
		.gpioOut (gpioOut),
		.gpioOe  (gpioOe),
		.pinOut  (port3Bit4Out),
		.pinOe   (port3Bit4Oe)
	);

	assign prdata             = prdata_ff;
	assign pready             = pready_ff;
	assign pslverr            = pslverr_ff;
	assign machineCycleStrobe = strobe_ff;
	assign instrTiming        = its_ff;

	// Helper logic for the checks below.
	logic       firstCycle_ff;
	logic [4:0] gapCnt_ff;
	logic [2:0] itsPrev_ff;
	logic       itsStable_ff;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			firstCycle_ff <= 1'b1;
			gapCnt_ff     <= 5'h00;
			itsPrev_ff    <= CTC_ITS_RST;
			itsStable_ff  <= 1'b0;
		end else begin
			firstCycle_ff <= 1'b0;
			gapCnt_ff     <= strobe_ff ? 5'h01 : gapCnt_ff + 5'h01;
			itsPrev_ff    <= its_ff;
			itsStable_ff  <= (its_ff != itsPrev_ff) ? 1'b0 : (strobe_ff ? 1'b1 : itsStable_ff);
		end
	end

	cycle_length_a: assert property (@(posedge mclk) disable iff (!rstn)
		(strobe_ff && itsStable_ff) |-> (gapCnt_ff == 5'(CTC_MCLK_PER_OSC * (int'(itsPrev_ff) + 1))))
		else $error("Machine cycle length does not match the timing field.");

	reset_value_a: assert property (@(posedge mclk) disable iff (!rstn)
		firstCycle_ff |-> (its_ff == CTC_ITS_RST && outSel_ff == CTC_SEL_RST))
		else $error("Configuration does not hold its reset value.");

	its_update_a: assert property (@(posedge mclk) disable iff (!rstn)
		wrCfg |=> (instrTiming == $past(pwdata[CTC_ITS_MSB:CTC_ITS_LSB])))
		else $error("Timing field write not applied on the next cycle.");

	sel_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
		wrCfg |-> ##2 (port3Bit4Oe == (($past(pwdata[CTC_SEL_MSB:CTC_SEL_LSB], 2) != 2'h0) || $past(gpioOe))))
		else $error("Pad drive does not follow a clock output select write.");

	// Every setup cycle is answered in the very next cycle, and pready was still low in the setup cycle itself.
	bus_answer_a: assert property (@(posedge mclk) disable iff (!rstn)
		(psel && !penable) |=> (pready && !$past(pready)))
		else $error("Bus answer not given in the cycle after setup.");

	strobe_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
		machineCycleStrobe |=> !machineCycleStrobe)
		else $error("Machine cycle strobe stands longer than one cycle.");

endmodule : ctc_cycle_timing

// file: hdl/ctc_pkg.sv
package ctc_pkg;

	// Register indices; the APB byte address is four times the index.
	localparam logic [7:0]  CTC_CFG_IDX      = 8'h8E;
	localparam logic [7:0]  CTC_STAT_IDX     = 8'h8F;

	function automatic logic [31:0] ctc_byte_addr(input logic [7:0] idx);
		return {22'h0, idx, 2'h0};
	endfunction : ctc_byte_addr

	localparam logic [31:0] CTC_CFG_ADDR     = ctc_byte_addr(CTC_CFG_IDX);
	localparam logic [31:0] CTC_STAT_ADDR    = ctc_byte_addr(CTC_STAT_IDX);

	// Clock configuration register layout and reset value.
	localparam logic [7:0]  CTC_CFG_RST      = 8'h10;
	localparam int          CTC_ITS_LSB      = 4;
	localparam int          CTC_ITS_MSB      = 6;
	localparam int          CTC_SEL_LSB      = 0;
	localparam int          CTC_SEL_MSB      = 1;
	localparam logic [2:0]  CTC_ITS_RST      = CTC_CFG_RST[CTC_ITS_MSB:CTC_ITS_LSB];

	// Status register layout.
	localparam int          CTC_STAT_CNT_LSB = 0;
	localparam int          CTC_STAT_PHASE   = 3;
	localparam int          CTC_STAT_PIN     = 4;

	// Clock output select codes, in field order.
	typedef enum logic [1:0] {
		CTC_SEL_GPIO,
		CTC_SEL_FOSC,
		CTC_SEL_DIV2,
		CTC_SEL_DIV4
	} ctc_sel_type;

	localparam ctc_sel_type CTC_SEL_RST      = ctc_sel_type'(CTC_CFG_RST[CTC_SEL_MSB:CTC_SEL_LSB]);

	// One oscillator clock spans this many mclk edges.
	localparam int          CTC_MCLK_PER_OSC = 2;
	localparam logic [2:0]  CTC_CNT_RST      = 3'h0;
	localparam logic [2:0]  CTC_DIV_RST      = 3'h0;

endpackage : ctc_pkg

// file: hdl/ctc_clock_out.sv
`timescale 1ns/100ps
module ctc_clock_out (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	// Mode and ordinary port function
	input  wire ctc_pkg::ctc_sel_type outSel,
	input  wire logic                 gpioOut,
	input  wire logic                 gpioOe,
	// Pad
	output logic                      pinOut,
	output logic                      pinOe
);
	import ctc_pkg::*;

	logic [2:0] divCnt_ff;
	logic [2:0] nxt_divCnt;
	logic       pinOut_ff;
	logic       nxt_pinOut;
	logic       pinOe_ff;
	logic       nxt_pinOe;

	// The divider runs free so that a mode switch never restarts the waveform phase.
	always_comb begin
		nxt_divCnt = divCnt_ff + 3'h1;
		nxt_pinOut = gpioOut;
		nxt_pinOe  = gpioOe;
		case (outSel)
			CTC_SEL_GPIO: begin
				nxt_pinOut = gpioOut;
				nxt_pinOe  = gpioOe;
			end
			CTC_SEL_FOSC: begin
				nxt_pinOut = divCnt_ff[0];
				nxt_pinOe  = 1'b1;
			end
			CTC_SEL_DIV2: begin
				nxt_pinOut = divCnt_ff[1];
				nxt_pinOe  = 1'b1;
			end
			CTC_SEL_DIV4: begin
				nxt_pinOut = divCnt_ff[2];
				nxt_pinOe  = 1'b1;
			end
			default: begin
				nxt_pinOut = gpioOut;
				nxt_pinOe  = gpioOe;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			divCnt_ff <= CTC_DIV_RST;
			pinOut_ff <= 1'b0;
			pinOe_ff  <= 1'b0;
		end else begin
			divCnt_ff <= nxt_divCnt;
			pinOut_ff <= nxt_pinOut;
			pinOe_ff  <= nxt_pinOe;
		end
	end

	assign pinOut = pinOut_ff;
	assign pinOe  = pinOe_ff;

	clock_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
		(outSel != CTC_SEL_GPIO) [*2] |-> pinOe)
		else $error("Clock output selected but pad not driven.");

	fosc_toggle_a: assert property (@(posedge mclk) disable iff (!rstn)
		(outSel == CTC_SEL_FOSC) [*3] |-> (pinOut != $past(pinOut)))
		else $error("Oscillator clock output does not toggle every edge.");

	div2_period_a: assert property (@(posedge mclk) disable iff (!rstn)
		(outSel == CTC_SEL_DIV2) [*4] |-> (pinOut != $past(pinOut, 2)))
		else $error("Half-rate clock output has the wrong period.");

	div4_period_a: assert property (@(posedge mclk) disable iff (!rstn)
		(outSel == CTC_SEL_DIV4) [*8] |-> (pinOut != $past(pinOut, 4)))
		else $error("Quarter-rate clock output has the wrong period.");

endmodule : ctc_clock_out

// file: bench/ctc_cycle_timing_test.sv
`timescale 1ns/100ps
module ctc_cycle_timing_test;
	import ctc_pkg::*;

	logic        mclk;
	logic        rstn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        gpioOut;
	logic        gpioOe;
	logic        machineCycleStrobe;
	logic [2:0]  instrTiming;
	logic        port3Bit4Out;
	logic        port3Bit4Oe;
	logic [31:0] rd;
	logic        er;
	int          errors;
	int          checked;
	int          cfgModel;
	int          g;
	int          t;
	localparam logic [11:0] CFG = CTC_CFG_ADDR[11:0];
	localparam logic [11:0] STAT = CTC_STAT_ADDR[11:0];

	ctc_cycle_timing #(.ADDR_W(12)) u_dut (
		.mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .gpioOut(gpioOut), .gpioOe(gpioOe),
		.machineCycleStrobe(machineCycleStrobe), .instrTiming(instrTiming),
		.port3Bit4Out(port3Bit4Out), .port3Bit4Oe(port3Bit4Oe)
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %0h seen %0h", name, exp, got);
		end
	endtask : check

	// One APB transfer; the request is held until pready is sampled high, and only the watchdog ends a wait.
	task automatic apb(logic [11:0] a, logic w, logic [31:0] d, logic [3:0] s);
		@(posedge mclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		pstrb <= s;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		if (w && s[0] && a == CFG)
			cfgModel = d & 32'h73;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Counts edges between two strobes, or between two pin changes.
	task automatic gap(bit pin, output int c);
		logic p;
		repeat (2) begin
			p = port3Bit4Out;
			c = 0;
			do begin
				@(posedge mclk);
				c++;
			end while (c < 40 && (pin ? port3Bit4Out === p : machineCycleStrobe !== 1'b1));
		end
	endtask : gap

	task automatic print_verdict;
		$display("Comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	initial begin
		#(20000 * 10);
		errors++;
		print_verdict();
	end

	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		gpioOut = 1'b0;
		gpioOe = 1'b0;
		errors = 0;
		checked = 0;
		cfgModel = 32'h10;
		void'($urandom(32'h9414));
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		apb(CFG, 1'b0, 32'h0, 4'h0);
		check("cfg reset", cfgModel, rd);
		check("timing reset", 32'h1, {29'h0, instrTiming});
		gap(1'b0, g);
		check("reset strobe period", 4, g);
		// Descending codes also cover a shorter cycle landing mid-count.
		for (t = 7; t >= 0; t--) begin
			apb(CFG, 1'b1, (t << 4) | ($urandom & 32'hFFFFFF8C), 4'hF);
			apb(CFG, 1'b0, 32'h0, 4'h0);
			check("cfg readback", cfgModel, rd);
			check("timing", t, {29'h0, instrTiming});
			gap(1'b0, g);
			check("strobe period", 2 * (t + 1), g);
		end
		apb(CFG, 1'b1, 32'h73, 4'hE);
		apb(CFG, 1'b0, 32'h0, 4'h0);
		check("cfg lane off", cfgModel, rd);
		apb(12'h100, 1'b0, 32'h0, 4'h0);
		check("unmapped error", 32'h1, {31'h0, er});
		check("unmapped data", 32'h0, rd);
		repeat (8) begin
			@(posedge mclk);
			gpioOut <= 1'($urandom);
			gpioOe <= 1'($urandom);
			@(posedge mclk);
			#1;
			check("pad port", {gpioOut, gpioOe}, {port3Bit4Out, port3Bit4Oe});
		end
		// Timing code 0 keeps the count at zero, and the pad shows the port level.
		apb(STAT, 1'b0, 32'h0, 4'h0);
		check("stat error", 32'h0, {31'h0, er});
		check("stat count", 32'h0, rd & 32'h7);
		check("stat pin", {31'h0, gpioOut}, rd >> 4);
		for (t = 1; t < 4; t++) begin
			apb(CFG, 1'b1, t, 4'h1);
			// Let the pad leave the old mode, so that the first edge found belongs to the new one.
			repeat (2) @(posedge mclk);
			gap(1'b1, g);
			check("clock half period", 1 << (t - 1), g);
			check("clock drive", 32'h1, {31'h0, port3Bit4Oe});
		end
		apb(CFG, 1'b1, 32'h0, 4'h1);
		repeat (3) @(posedge mclk);
		#1;
		check("pad back to port", {gpioOut, gpioOe}, {port3Bit4Out, port3Bit4Oe});
		// A reset in mid-run must bring back the reset values over those written since.
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (4) @(posedge mclk);
		check("pad in reset", 32'h0, {30'h0, port3Bit4Out, port3Bit4Oe});
		rstn <= 1'b1;
		cfgModel = 32'h10;
		apb(CFG, 1'b0, 32'h0, 4'h0);
		check("cfg after reset", cfgModel, rd);
		check("timing after reset", 32'h1, {29'h0, instrTiming});
		print_verdict();
	end
endmodule : ctc_cycle_timing_test
